//--- bench/lsc_engine_model.sv
// far-side station engine model: per-slot link state image and three events
// assumes the pclk domain and stat_slot choosing the station shown
`timescale 1ns/10ps
`default_nettype none
module lsc_engine_model
(
    // clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // station view
    input  wire logic [2:0]          stat_slot,
    output logic      [63:0]         link_state_bytes,
    output logic      [255:0]        tx_header,
    output logic                     evt_valid,
    output logic      [2:0]          evt_slot,
    output var lsc_pkg::lsc_event_t  evt_kind
);
    logic [3:0] cnt_q;
    // bytes carry the slot so that a wrong selection shows in the image
    assign link_state_bytes = {8{5'h15, stat_slot}};
    assign tx_header        = {32{8'hA5}};
    assign evt_slot         = 3'h1;
    assign evt_kind         = (cnt_q == 4'hC) ? lsc_pkg::ev_buf_busy :
                              (cnt_q == 4'hD) ? lsc_pkg::ev_rx_err :
                                                lsc_pkg::ev_tx_ok;
    // buffer busy, a receive error and a sent frame on slot 1, before any
    // command, so that busy clearing and counter clearing both show
    assign evt_valid        = (cnt_q >= 4'hC) && (cnt_q <= 4'hE);
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            cnt_q <= 4'h0;
        else if (cnt_q != 4'hF)
            cnt_q <= cnt_q + 4'h1;
endmodule : lsc_engine_model
`default_nettype wire

//--- bench/tb_lsc_station_cmd.sv
// testbench of the station command handler: apb tasks and command runs
// assumes the engine model on the far side and the register map header
`timescale 1ns/10ps
`default_nettype none
`include "lsc_consts.svh"
module tb_lsc_station_cmd;
    logic        pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, mod_done = 1'b0, pready, pslverr, pslv;
    logic [7:0]  paddr = 8'h00, mod_sap = 8'h00, local_busy;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] mod_code = 16'h0, mod_station = 16'h0;
    logic [2:0]  evt_slot, stat_slot;
    logic        evt_valid, cmd_complete, cmd_reject;
    int          n_done = 0, n_rej = 0;
    logic [63:0] link_state_bytes;
    logic [255:0] tx_header;
    lsc_pkg::lsc_event_t evt_kind;
    int          mismatches = 0, tests_run = 0, cyc = 0;

    lsc_station_cmd DUT (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .mod_done, .mod_code,
        .mod_station, .mod_sap, .evt_valid, .evt_slot, .evt_kind,
        .link_state_bytes, .tx_header, .stat_slot, .local_busy,
        .cmd_complete, .cmd_reject);
    lsc_engine_model u_eng (.pclk, .presetn, .stat_slot, .link_state_bytes,
        .tx_header, .evt_valid, .evt_slot, .evt_kind);

    task automatic conclude;
        if (mismatches == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd      = prdata;
        pslv    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // clears the sticky flags, issues one command, waits for done or reject
    task automatic cmd(input logic [15:0] c, input logic [15:0] p0,
                       input logic [15:0] p1);
        apb(1'b1, `LSC_A_STAT, 32'h00000003);
        apb(1'b1, `LSC_A_CMDW, {16'h0000, c});
        apb(1'b1, `LSC_A_P0, {16'h0000, p0});
        apb(1'b1, `LSC_A_P1, {16'h0000, p1});
        apb(1'b1, `LSC_A_GO, 32'h00000001);
        do
            apb(1'b0, `LSC_A_STAT, 32'h0);
        while (rd[1:0] == 2'b00);
    endtask : cmd

    task automatic st(input logic [15:0] c, input logic [15:0] s0,
                      input logic [15:0] s1, input logic [15:0] s2);
        apb(1'b0, `LSC_A_SCMD, 32'h0);
        chk(rd, {16'h0000, c});
        apb(1'b0, `LSC_A_SP0, 32'h0);
        chk(rd, {16'h0000, s0});
        apb(1'b0, `LSC_A_SP1, 32'h0);
        chk(rd, {16'h0000, s1});
        apb(1'b0, `LSC_A_SP2, 32'h0);
        chk(rd, {16'h0000, s2});
    endtask : st

    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cyc++;
        if (cmd_complete === 1'b1)
            n_done++;
        if (cmd_reject === 1'b1)
            n_rej++;
        if (cyc == 20000)
        begin
            mismatches++;
            conclude();
        end
    end

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'hFC, 32'h0);
        chk(pslv, 1'b1);
        cmd(`LSC_OP_FLOW, 16'h0101, 16'h0000);
        chk(rd[1:0], 2'b10);
        apb(1'b1, `LSC_A_CTRL, 32'h00000003);
        apb(1'b1, `LSC_A_SLOT, 32'h80010101);
        cmd(`LSC_OP_FLOW, 16'h0100, 16'h0002);
        chk(local_busy, 8'h02);
        st(`LSC_OP_FLOW, `LSC_CS_GOOD, 16'h0100, 16'h0000);
        cmd(`LSC_OP_FLOW, 16'h0000, 16'h0001);
        chk(local_busy, 8'h02);
        cmd(`LSC_OP_FLOW, 16'h0101, 16'h0003);
        chk(local_busy, 8'h02);
        cmd(`LSC_OP_FLOW, 16'h0101, 16'h0001);
        chk(local_busy, 8'h00);
        cmd(`LSC_OP_FLOW, 16'h0505, 16'h0000);
        st(`LSC_OP_FLOW, `LSC_CS_BADSTA, 16'h0505, 16'h0000);
        @(posedge pclk);
        mod_done    <= 1'b1;
        mod_code    <= `LSC_CS_NOGRP;
        mod_station <= 16'h0202;
        mod_sap     <= 8'h44;
        @(posedge pclk);
        mod_done    <= 1'b0;
        st(`LSC_OP_MODIFY, `LSC_CS_NOGRP, 16'h0202, 16'h0044);
        apb(1'b1, `LSC_A_REQ_STA, 32'h00000101);
        apb(1'b1, `LSC_A_REQ_LEN, 32'h00000030);
        apb(1'b1, `LSC_A_REQ_OPT, 32'h0000FFFE);
        cmd(`LSC_OP_STATS, 16'hAB00, 16'h0040);
        apb(1'b0, `LSC_A_REQ_PTR, 32'h0);
        chk(rd, 32'h00000040);
        st(`LSC_OP_STATS, `LSC_CS_GOOD, 16'h0101, 16'h0000);
        apb(1'b0, `LSC_A_REQ_RET, 32'h0);
        chk(rd, 32'h00000030);
        apb(1'b0, `LSC_A_BUF, 32'h0);
        chk(rd, 32'h00000100);
        apb(1'b0, 8'h84, 32'h0);
        chk(rd, 32'h00000001);
        apb(1'b0, 8'h88, 32'h0);
        chk(rd, 32'h29A9A9A9);
        apb(1'b0, 8'h8C, 32'h0);
        chk(rd, 32'hA9A9A9A9);
        apb(1'b0, 8'h90, 32'h0);
        chk(rd, 32'hA5A5A5A5);
        apb(1'b1, `LSC_A_REQ_LEN, 32'h00000004);
        cmd(`LSC_OP_STATS, 16'h0000, 16'h0040);
        st(`LSC_OP_STATS, `LSC_CS_LOST, 16'h0101, 16'h0000);
        apb(1'b1, `LSC_A_REQ_LEN, 32'h00000030);
        apb(1'b1, `LSC_A_REQ_OPT, 32'h00000001);
        cmd(`LSC_OP_STATS, 16'h0000, 16'h0040);
        apb(1'b0, 8'h84, 32'h0);
        chk(rd, 32'h00000001);
        cmd(`LSC_OP_STATS, 16'h0000, 16'h0040);
        apb(1'b0, 8'h84, 32'h0);
        chk(rd, 32'h00000000);
        apb(1'b1, `LSC_A_REQ_LEN, 32'h00000010);
        cmd(`LSC_OP_STATS, 16'h0000, 16'h0040);
        st(`LSC_OP_STATS, `LSC_CS_LOST, 16'h0101, 16'h0000);
        apb(1'b0, `LSC_A_REQ_RET, 32'h0);
        chk(rd, 32'h00000030);
        chk(n_rej, 32'h00000001);
        chk(n_done, 32'h0000000B);
        conclude();
    end
endmodule : tb_lsc_station_cmd
`default_nettype wire

//--- hdl/lsc_consts.svh
// constants of the station command handler: register offsets, field
// positions, command and completion codes, image layout.
// assumes an 8-bit byte address on the register bus.
`ifndef LSC_CONSTS_SVH
`define LSC_CONSTS_SVH

`define LSC_A_CTRL      8'h00
`define LSC_A_CMDW      8'h04
`define LSC_A_P0        8'h08
`define LSC_A_P1        8'h0C
`define LSC_A_GO        8'h10
`define LSC_A_SCMD      8'h14
`define LSC_A_SP0       8'h18
`define LSC_A_SP1       8'h1C
`define LSC_A_SP2       8'h20
`define LSC_A_STAT      8'h24
`define LSC_A_SLOT      8'h28
`define LSC_A_REQ_STA   8'h30
`define LSC_A_REQ_LEN   8'h34
`define LSC_A_REQ_AHI   8'h38
`define LSC_A_REQ_ALO   8'h3C
`define LSC_A_REQ_RET   8'h40
`define LSC_A_REQ_OPT   8'h44
`define LSC_A_REQ_PTR   8'h48
`define LSC_A_BUF       8'h80
`define LSC_BUF_SPAN    8'h30

`define LSC_CTRL_OPEN   0
`define LSC_CTRL_LLC    1
`define LSC_STAT_DONE   0
`define LSC_STAT_REJ    1
`define LSC_STAT_BUSY   2
`define LSC_SLOT_VALID  31
`define LSC_FLOW_STAT   0
`define LSC_FLOW_COND   1
`define LSC_OPT_RESET   0

`define LSC_OP_MODIFY   16'h001C
`define LSC_OP_FLOW     16'h001D
`define LSC_OP_STATS    16'h001E

`define LSC_CS_GOOD     16'h0000
`define LSC_CS_PRIO     16'h0008
`define LSC_CS_LOST     16'h0015
`define LSC_CS_BADSTA   16'h0040
`define LSC_CS_MAXPAR   16'h0042
`define LSC_CS_NOGRP    16'h0045
`define LSC_CS_GRPFULL  16'h0049
`define LSC_CS_NOMEMB   16'h004E

`define LSC_RST_WORD    16'h0000
`define LSC_IMG_LEN     16'h0030
`define LSC_MIN_CLR     16'h0008
`define LSC_LAST_WORD   4'hB

`endif

//--- hdl/lsc_pkg.sv
// types of the station command handler.
// assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package lsc_pkg;
    typedef enum logic [1:0] {st_idle, st_copy, st_fin} lsc_state_t;
    typedef enum logic [2:0] {ev_tx_ok, ev_rx_ok, ev_rx_err, ev_tx_err,
                              ev_t1_idle, ev_buf_busy} lsc_event_t;
endpackage : lsc_pkg
`default_nettype wire

//--- hdl/lsc_station_cmd.sv
// station command handler: flow regulation, counter readout, parameter
// update completion reporting, with an APB register file.
// assumes station engine events and link state on the pclk domain.
// How it works
// - update done: complete, 001C, code, station
// - group failures 0045/0049 report group point
// - update code limited to seven legal values
// - flow regulation to station zero changes nothing
// - reject both commands unless opened and enabled
// - low byte zero selects whole group point
// - option bit0 zero enters busy, bit1 ignored
// - bit0 one clears busy cause chosen by bit1
// - flow done: complete, 001D, code, station, zero
// - readout pointer 24 bits, top byte ignored
// - request block: station, length, address, size, options
// - returned size is full image length
// - option bit0 clears error counters after readout
// - option bits 1-15 ignored
// - image bytes 0-7 hold counts
// - bytes 8-10 control bytes and primary state
// - byte 11 secondary state, bit7 zero
// - bytes 12-14 send, receive, last received counts
// - byte 15 header length, 16-47 header
// - readout done: complete, 001E, code, station, zero
// - codes 0000/0040/0015; no clear below eight
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "lsc_consts.svh"

module lsc_station_cmd
#(
    parameter int NST = 8,
    parameter int SW  = $clog2(NST)
)
(
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // parameter update completion from the update unit
    input  wire logic               mod_done,
    input  wire logic [15:0]        mod_code,
    input  wire logic [15:0]        mod_station,
    input  wire logic [7:0]         mod_sap,
    // station engine events and state
    input  wire logic               evt_valid,
    input  wire logic [SW-1:0]      evt_slot,
    input  wire lsc_pkg::lsc_event_t evt_kind,
    input  wire logic [63:0]        link_state_bytes,
    input  wire logic [255:0]       tx_header,
    // results
    output logic [SW-1:0]           stat_slot,
    output logic [NST-1:0]          local_busy,
    output logic                    cmd_complete,
    output logic                    cmd_reject
);

    typedef struct packed {
        lsc_pkg::lsc_state_t     state;
        logic [1:0]              ctrl;
        logic [15:0]             cmdw, p0, p1;
        logic [15:0]             scmd, sp0, sp1, sp2;
        logic                    go, done_f, rej_f, done_p, rej_p;
        logic [NST-1:0][15:0]    slot_id;
        logic [NST-1:0]          slot_v, ubusy, bbusy, lbusy;
        logic [NST-1:0][15:0]    cnt_tx, cnt_rx, cnt_t1;
        logic [NST-1:0][7:0]     cnt_rxe, cnt_txe;
        logic [15:0]             req_sta, req_len, req_ahi, req_alo;
        logic [15:0]             req_ret, req_opt;
        logic [11:0][31:0]       bufw;
        logic [3:0]              widx;
        logic [SW-1:0]           sel;
        logic                    mod_pend;
        logic [15:0]             mod_code, mod_sta;
        logic [7:0]              mod_sap;
        logic                    pready, pslverr;
        logic [31:0]             prdata;
    } lsc_regs_t;

    lsc_regs_t q, d;

    logic [NST-1:0] flow_hit;
    logic [NST-1:0] stat_hit;

    // station matching, exact or whole group point for flow, exact only for readout
    genvar g;
    generate
        for (g = 0; g < NST; g++)
        begin : g_match
            assign flow_hit[g] = q.slot_v[g] &&
                ((q.p0[7:0] == 8'h00) ?
                 (q.slot_id[g][15:8] == q.p0[15:8]) :
                 (q.slot_id[g] == q.p0));
            assign stat_hit[g] = q.slot_v[g] && q.req_sta[7:0] != 8'h00 &&
                                 q.slot_id[g] == q.req_sta;
        end
    endgenerate

    always_comb
    begin
        logic [47:0][7:0] img;
        logic             acc, wr, hit, ok;
        logic [7:0]       boff;
        logic [15:0]      code, bi;
        logic             clr;
        int               i;
        int               k;
        img  = '0;
        acc  = 1'b0;
        wr   = 1'b0;
        hit  = 1'b0;
        ok   = 1'b0;
        boff = 8'h00;
        code = `LSC_CS_GOOD;
        bi   = 16'h0000;
        clr  = 1'b0;
        i    = 0;
        k    = 0;
        d    = q;
        d.done_p = 1'b0;
        d.rej_p  = 1'b0;
        d.pready = 1'b0;

        // statistics image of the selected station
        img[0] = q.cnt_tx[q.sel][15:8];
        img[1] = q.cnt_tx[q.sel][7:0];
        img[2] = q.cnt_rx[q.sel][15:8];
        img[3] = q.cnt_rx[q.sel][7:0];
        img[4] = q.cnt_rxe[q.sel];
        img[5] = q.cnt_txe[q.sel];
        img[6] = q.cnt_t1[q.sel][15:8];
        img[7] = q.cnt_t1[q.sel][7:0];
        for (k = 0; k < 8; k++)
            img[8+k] = link_state_bytes[8*k +: 8];
        img[11][1] = q.ubusy[q.sel];
        img[11][2] = q.bbusy[q.sel];
        img[11][7] = 1'b0;
        for (k = 0; k < 32; k++)
            img[16+k] = tx_header[8*k +: 8];

        // apb: one wait state, writes land on the completing edge
        boff = paddr - `LSC_A_BUF;
        acc  = psel && penable && !q.pready;
        wr   = psel && penable && pwrite && q.pready && !q.pslverr;
        if (acc)
        begin
            d.pready  = 1'b1;
            d.pslverr = 1'b0;
            d.prdata  = 32'h0000_0000;
            case (paddr)
                `LSC_A_CTRL:    d.prdata[1:0] = q.ctrl;
                `LSC_A_CMDW:    d.prdata[15:0] = q.cmdw;
                `LSC_A_P0:      d.prdata[15:0] = q.p0;
                `LSC_A_P1:      d.prdata[15:0] = q.p1;
                `LSC_A_GO:      d.prdata[0] = q.go;
                `LSC_A_SCMD:    d.prdata[15:0] = q.scmd;
                `LSC_A_SP0:     d.prdata[15:0] = q.sp0;
                `LSC_A_SP1:     d.prdata[15:0] = q.sp1;
                `LSC_A_SP2:     d.prdata[15:0] = q.sp2;
                `LSC_A_STAT:    d.prdata[2:0] = {q.go ||
                    q.state != lsc_pkg::st_idle, q.rej_f, q.done_f};
                `LSC_A_SLOT:    d.prdata = {15'h0000, 1'b0, 16'h0000};
                `LSC_A_REQ_STA: d.prdata[15:0] = q.req_sta;
                `LSC_A_REQ_LEN: d.prdata[15:0] = q.req_len;
                `LSC_A_REQ_AHI: d.prdata[15:0] = q.req_ahi;
                `LSC_A_REQ_ALO: d.prdata[15:0] = q.req_alo;
                `LSC_A_REQ_RET: d.prdata[15:0] = q.req_ret;
                `LSC_A_REQ_OPT: d.prdata[15:0] = q.req_opt;
                `LSC_A_REQ_PTR: d.prdata[23:0] = {q.p0[7:0], q.p1};
                default:
                begin
                    if (boff < `LSC_BUF_SPAN && paddr[1:0] == 2'b00)
                        d.prdata = q.bufw[boff[5:2]];
                    else
                        d.pslverr = 1'b1;
                end
            endcase
        end
        else if (!(psel && penable))
            d.pslverr = 1'b0;

        if (wr)
        begin
            case (paddr)
                `LSC_A_CTRL:    d.ctrl = pwdata[1:0];
                `LSC_A_CMDW:    d.cmdw = pwdata[15:0];
                `LSC_A_P0:      d.p0 = pwdata[15:0];
                `LSC_A_P1:      d.p1 = pwdata[15:0];
                `LSC_A_GO:      d.go = q.go || pwdata[0];
                `LSC_A_STAT:
                begin
                    d.done_f = q.done_f && !pwdata[`LSC_STAT_DONE];
                    d.rej_f  = q.rej_f && !pwdata[`LSC_STAT_REJ];
                end
                `LSC_A_SLOT:
                begin
                    d.slot_id[pwdata[16+SW-1:16]] = pwdata[15:0];
                    d.slot_v[pwdata[16+SW-1:16]]  = pwdata[`LSC_SLOT_VALID];
                end
                `LSC_A_REQ_STA: d.req_sta = pwdata[15:0];
                `LSC_A_REQ_LEN: d.req_len = pwdata[15:0];
                `LSC_A_REQ_AHI: d.req_ahi = {8'h00, pwdata[7:0]};
                `LSC_A_REQ_ALO: d.req_alo = pwdata[15:0];
                `LSC_A_REQ_OPT: d.req_opt = pwdata[15:0];
                default:        d.go = q.go;
            endcase
        end

        if (mod_done)
        begin
            d.mod_pend = 1'b1;
            d.mod_code = mod_code;
            d.mod_sta  = mod_station;
            d.mod_sap  = mod_sap;
        end

        case (q.state)
            lsc_pkg::st_idle:
            begin
                if (q.mod_pend)
                begin
                    d.mod_pend = mod_done;
                    d.scmd = `LSC_OP_MODIFY;
                    d.sp1  = q.mod_sta;
                    d.sp2  = `LSC_RST_WORD;
                    case (q.mod_code)
                        `LSC_CS_GOOD, `LSC_CS_PRIO, `LSC_CS_BADSTA,
                        `LSC_CS_MAXPAR, `LSC_CS_NOMEMB:
                            d.sp0 = q.mod_code;
                        `LSC_CS_NOGRP, `LSC_CS_GRPFULL:
                        begin
                            d.sp0 = q.mod_code;
                            d.sp2 = {8'h00, q.mod_sap};
                        end
                        default: d.sp0 = `LSC_CS_MAXPAR;
                    endcase
                    d.done_p = 1'b1;
                end
                else if (q.go)
                begin
                    d.go = 1'b0;
                    ok = q.ctrl[`LSC_CTRL_OPEN] && q.ctrl[`LSC_CTRL_LLC];
                    if (!ok || (q.cmdw != `LSC_OP_FLOW &&
                                q.cmdw != `LSC_OP_STATS))
                        d.rej_p = 1'b1;
                    else if (q.cmdw == `LSC_OP_FLOW)
                    begin
                        code = (q.p0 == 16'h0000 || |flow_hit) ?
                               `LSC_CS_GOOD : `LSC_CS_BADSTA;
                        if (q.p0 != 16'h0000)
                        begin
                            for (i = 0; i < NST; i++)
                            begin
                                if (flow_hit[i])
                                begin
                                    if (!q.p1[`LSC_FLOW_STAT])
                                        d.ubusy[i] = 1'b1;
                                    else if (!q.p1[`LSC_FLOW_COND])
                                        d.ubusy[i] = 1'b0;
                                    else
                                        d.bbusy[i] = 1'b0;
                                end
                            end
                        end
                        d.scmd   = `LSC_OP_FLOW;
                        d.sp0    = code;
                        d.sp1    = q.p0;
                        d.sp2    = `LSC_RST_WORD;
                        d.done_p = 1'b1;
                    end
                    else
                    begin
                        for (i = NST - 1; i >= 0; i--)
                        begin
                            if (stat_hit[i])
                            begin
                                hit   = 1'b1;
                                d.sel = SW'(i);
                            end
                        end
                        if (hit)
                        begin
                            d.widx  = 4'h0;
                            d.state = lsc_pkg::st_copy;
                        end
                        else
                        begin
                            d.scmd   = `LSC_OP_STATS;
                            d.sp0    = `LSC_CS_BADSTA;
                            d.sp1    = q.req_sta;
                            d.sp2    = `LSC_RST_WORD;
                            d.done_p = 1'b1;
                        end
                    end
                end
            end
            lsc_pkg::st_copy:
            begin
                // only bytes inside the host buffer length are written
                for (k = 0; k < 4; k++)
                begin
                    bi = {10'h000, q.widx, 2'(k)};
                    if (bi < q.req_len)
                        d.bufw[q.widx][8*k +: 8] = img[bi[5:0]];
                end
                d.widx = q.widx + 4'h1;
                if (q.widx == `LSC_LAST_WORD)
                    d.state = lsc_pkg::st_fin;
            end
            lsc_pkg::st_fin:
            begin
                d.req_ret = `LSC_IMG_LEN;
                code = (q.req_len < `LSC_IMG_LEN) ? `LSC_CS_LOST
                                                  : `LSC_CS_GOOD;
                // only option bit0 is looked at
                clr = (q.req_opt[`LSC_OPT_RESET] ||
                       code == `LSC_CS_LOST) &&
                      q.req_len >= `LSC_MIN_CLR;
                if (clr)
                begin
                    d.cnt_rxe[q.sel] = 8'h00;
                    d.cnt_txe[q.sel] = 8'h00;
                    d.cnt_t1[q.sel]  = 16'h0000;
                end
                d.scmd   = `LSC_OP_STATS;
                d.sp0    = code;
                d.sp1    = q.req_sta;
                d.sp2    = `LSC_RST_WORD;
                d.done_p = 1'b1;
                d.state  = lsc_pkg::st_idle;
            end
            default: d.state = lsc_pkg::st_idle;
        endcase

        // station events come last so a same-cycle set beats a clear
        if (evt_valid)
        begin
            case (evt_kind)
                lsc_pkg::ev_tx_ok:
                    d.cnt_tx[evt_slot] = q.cnt_tx[evt_slot] + 16'h0001;
                lsc_pkg::ev_rx_ok:
                    d.cnt_rx[evt_slot] = q.cnt_rx[evt_slot] + 16'h0001;
                lsc_pkg::ev_rx_err:
                    d.cnt_rxe[evt_slot] = d.cnt_rxe[evt_slot] + 8'h01;
                lsc_pkg::ev_tx_err:
                    d.cnt_txe[evt_slot] = d.cnt_txe[evt_slot] + 8'h01;
                lsc_pkg::ev_t1_idle:
                    d.cnt_t1[evt_slot] = d.cnt_t1[evt_slot] + 16'h0001;
                lsc_pkg::ev_buf_busy: d.bbusy[evt_slot] = 1'b1;
                default: d.bbusy = d.bbusy;
            endcase
        end
        if (d.done_p)
            d.done_f = 1'b1;
        if (d.rej_p)
            d.rej_f = 1'b1;
        d.lbusy = d.ubusy | d.bbusy;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q <= '0;
        else
            q <= d;
    end

    assign prdata       = q.prdata;
    assign pready       = q.pready;
    assign pslverr      = q.pslverr;
    assign stat_slot    = q.sel;
    assign local_busy   = q.lbusy;
    assign cmd_complete = q.done_p;
    assign cmd_reject   = q.rej_p;

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic take, cmd_ok;
    assign take   = q.state == lsc_pkg::st_idle && !q.mod_pend && q.go;
    assign cmd_ok = q.ctrl == 2'b11;

    sequence s_stats_start;
        take && cmd_ok && q.cmdw == `LSC_OP_STATS && |stat_hit;
    endsequence
    sequence s_stats_end;
        q.done_p && q.scmd == `LSC_OP_STATS && q.req_ret == `LSC_IMG_LEN;
    endsequence

    a_modify_code_legal: assert property (
        q.done_p && q.scmd == `LSC_OP_MODIFY |-> q.sp0 inside
        {`LSC_CS_GOOD, `LSC_CS_PRIO, `LSC_CS_BADSTA, `LSC_CS_MAXPAR,
         `LSC_CS_NOGRP, `LSC_CS_GRPFULL, `LSC_CS_NOMEMB})
        else $error("update completion code out of set");
    a_modify_group_point: assert property (
        q.state == lsc_pkg::st_idle && q.mod_pend &&
        q.mod_code inside {`LSC_CS_NOGRP, `LSC_CS_GRPFULL} |=>
        q.done_p && q.sp2 == {8'h00, $past(q.mod_sap)} &&
        q.sp1 == $past(q.mod_sta))
        else $error("group point not reported");
    a_flow_null_station: assert property (
        take && cmd_ok && q.cmdw == `LSC_OP_FLOW && q.p0 == 16'h0000
        && !evt_valid |=> q.done_p && $stable(q.lbusy))
        else $error("station zero changed busy state");
    a_cmd_reject_gate: assert property (
        take && !cmd_ok |=> q.rej_p && !q.done_p && q.rej_f)
        else $error("command not rejected while closed");
    a_flow_enter_busy: assert property (
        take && cmd_ok && q.cmdw == `LSC_OP_FLOW && q.p0 != 16'h0000
        && !q.p1[0] |=> (q.ubusy & $past(flow_hit)) == $past(flow_hit))
        else $error("busy not entered");
    a_flow_user_clear: assert property (
        take && cmd_ok && q.cmdw == `LSC_OP_FLOW && q.p0 != 16'h0000
        && q.p1[1:0] == 2'b01 |=> (q.ubusy & $past(flow_hit)) == '0)
        else $error("user busy not cleared");
    a_flow_status: assert property (
        q.done_p && q.scmd == `LSC_OP_FLOW |-> q.sp2 == 16'h0000 &&
        (q.sp0 == `LSC_CS_GOOD || q.sp0 == `LSC_CS_BADSTA))
        else $error("flow status block wrong");
    a_stats_walk: assert property (
        s_stats_start |-> ##14 s_stats_end)
        else $error("readout did not finish in fourteen cycles");
    a_short_no_clear: assert property (
        q.state == lsc_pkg::st_fin && q.req_len < `LSC_MIN_CLR &&
        !evt_valid |=> $stable(q.cnt_rxe) && q.sp0 == `LSC_CS_LOST)
        else $error("counters cleared with short buffer");

endmodule : lsc_station_cmd

`default_nettype wire
